// ---- pressure_reference_offset_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1 - register 15h holds reference pressure bits 7:0, read and write.
// R2 - register 16h holds reference pressure bits 15:8, read and write.
// R3 - register 17h holds reference pressure bits 23:16, read and write.
// R4 - the 24-bit reference pressure is added to the sensor output pressure.
// R5 - register 18h holds solder offset bits 7:0, read and write.
// R6 - offset is {19h,18h}, signed two's complement, 19h the upper byte.
// R7 - the solder offset is applied in the differential pressure result.
// R8 - register 19h holds solder offset bits 15:8, read and write, reset zero.
module pressure_reference_offset_regs
  import pressure_reference_offset_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire reg_request_type REG_REQUEST,
  output logic [REG_DATA_WIDTH-1:0] REG_RDATA,
  output logic REG_RVALID,
  input wire sample_type RAW_PRESSURE,
  output sample_type PRESSURE_RESULT
);

  ////////////////////////////////////////////////////////////////////////////
  // register bytes

  logic [REG_DATA_WIDTH-1:0] bank [BYTE_COUNT];

  // the bank is indexed by address minus the base, so its size must match the address span
  if (int'(ADDR_SOLDER_OFFSET_HIGH - ADDR_REFERENCE_PRESSURE_LOW) + 1 != BYTE_COUNT) begin : gen_bad_span
    $error("register bank size does not match its address span");
  end

  genvar g;
  generate
    for (g = 0; g < BYTE_COUNT; g++) begin : gen_byte
      host_byte_register #(
        .ADDRESS(ADDR_REFERENCE_PRESSURE_LOW + 8'(g))
      ) u_byte (
        .clock(CLOCK),
        .reset(SYS_RST),
        .request(REG_REQUEST),
        .value(bank[g])
      );
    end
  endgenerate

  wire [PRESSURE_WIDTH-1:0] reference_pressure_bits;
  wire [OFFSET_WIDTH-1:0] solder_offset_bits;
  wire signed [PRESSURE_WIDTH-1:0] offset_extended;
  wire [PRESSURE_WIDTH-1:0] next_result;

  assign reference_pressure_bits = {bank[IDX_REF_HIGH], bank[IDX_REF_MID], bank[IDX_REF_LOW]}; // [R1] [R2] [R3]
  assign solder_offset_bits = {bank[IDX_OFF_HIGH], bank[IDX_OFF_LOW]}; // [R5] [R6] [R8]
  // sign extension makes a negative offset lower the result
  assign offset_extended = PRESSURE_WIDTH'($signed(solder_offset_bits)); // [R6]
  // sums wrap at 24 bits, matching the width of the sensor output word
  assign next_result = RAW_PRESSURE.value + reference_pressure_bits + offset_extended; // [R4] [R7]

  ////////////////////////////////////////////////////////////////////////////
  // read port: answer one cycle after the read strobe

  wire in_range;
  wire [REG_DATA_WIDTH-1:0] next_rdata;
  wire [7:0] read_index;

  assign in_range = (REG_REQUEST.addr >= ADDR_REFERENCE_PRESSURE_LOW) &&
                    (REG_REQUEST.addr <= ADDR_SOLDER_OFFSET_HIGH);
  assign read_index = REG_REQUEST.addr - ADDR_REFERENCE_PRESSURE_LOW;
  assign next_rdata = in_range ? bank[read_index[2:0]] : UNMAPPED_READ_VALUE;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      REG_RDATA <= UNMAPPED_READ_VALUE;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQUEST.read;
      if (REG_REQUEST.read) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pressure result

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      PRESSURE_RESULT <= '0;
    end else begin
      PRESSURE_RESULT.valid <= RAW_PRESSURE.valid;
      if (RAW_PRESSURE.valid) begin
        PRESSURE_RESULT.value <= next_result; // [R4] [R7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_ref_low_rw;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.write && REG_REQUEST.addr == ADDR_REFERENCE_PRESSURE_LOW)
    ##1 (!REG_REQUEST.write && REG_REQUEST.read && REG_REQUEST.addr == ADDR_REFERENCE_PRESSURE_LOW)
    |=> REG_RVALID && REG_RDATA == $past(REG_REQUEST.wdata, 2);
  endproperty
  a_ref_low_rw: assert property (p_ref_low_rw) else $error("15h does not read back"); // [R1]

  property p_ref_mid;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.write && REG_REQUEST.addr == ADDR_REFERENCE_PRESSURE_MID)
    |=> reference_pressure_bits[15:8] == $past(REG_REQUEST.wdata);
  endproperty
  a_ref_mid: assert property (p_ref_mid) else $error("16h not in bits 15:8"); // [R2]

  property p_ref_high;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.write && REG_REQUEST.addr == ADDR_REFERENCE_PRESSURE_HIGH)
    |=> reference_pressure_bits[23:16] == $past(REG_REQUEST.wdata) && $stable(reference_pressure_bits[15:0]);
  endproperty
  a_ref_high: assert property (p_ref_high) else $error("17h not in bits 23:16"); // [R3]

  property p_sum;
    @(posedge CLOCK) disable iff (SYS_RST)
    (RAW_PRESSURE.valid && solder_offset_bits == 16'h0000)
    |=> PRESSURE_RESULT.valid &&
        PRESSURE_RESULT.value == PRESSURE_WIDTH'($past(RAW_PRESSURE.value) + $past(reference_pressure_bits));
  endproperty
  a_sum: assert property (p_sum) else $error("reference not added"); // [R4]

  property p_off_low;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.write && REG_REQUEST.addr == ADDR_SOLDER_OFFSET_LOW)
    |=> solder_offset_bits[7:0] == $past(REG_REQUEST.wdata);
  endproperty
  a_off_low: assert property (p_off_low) else $error("18h not in offset bits 7:0"); // [R5]

  // a negative offset plus its magnitude must give back the plain sum
  property p_signed;
    @(posedge CLOCK) disable iff (SYS_RST)
    (RAW_PRESSURE.valid && solder_offset_bits[OFFSET_WIDTH-1])
    |=> PRESSURE_WIDTH'(PRESSURE_RESULT.value + PRESSURE_WIDTH'(OFFSET_WIDTH'(~$past(solder_offset_bits) + 1'b1))) ==
        PRESSURE_WIDTH'($past(RAW_PRESSURE.value) + $past(reference_pressure_bits));
  endproperty
  a_signed: assert property (p_signed) else $error("offset sign lost"); // [R6]

  property p_offset_applied;
    @(posedge CLOCK) disable iff (SYS_RST)
    RAW_PRESSURE.valid ##1 !RAW_PRESSURE.valid
    |-> PRESSURE_WIDTH'(PRESSURE_RESULT.value - $past(reference_pressure_bits)) ==
        PRESSURE_WIDTH'($past(RAW_PRESSURE.value) +
        {{(PRESSURE_WIDTH - OFFSET_WIDTH){$past(solder_offset_bits[OFFSET_WIDTH-1])}}, $past(solder_offset_bits)});
  endproperty
  a_offset_applied: assert property (p_offset_applied) else $error("offset not applied"); // [R7]

  property p_off_high_reset;
    @(posedge CLOCK)
    SYS_RST |=> bank[IDX_OFF_HIGH] == BYTE_RESET_VALUE && solder_offset_bits[15:8] == BYTE_RESET_VALUE;
  endproperty
  a_off_high_reset: assert property (p_off_high_reset) else $error("19h not zero after reset"); // [R8]

  property p_ref_low_write;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.write && REG_REQUEST.addr == ADDR_REFERENCE_PRESSURE_LOW)
    |=> reference_pressure_bits[7:0] == $past(REG_REQUEST.wdata) && $stable(reference_pressure_bits[23:8]);
  endproperty
  a_ref_low_write: assert property (p_ref_low_write) else $error("15h not in bits 7:0"); // [R1]

  property p_off_high_write;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.write && REG_REQUEST.addr == ADDR_SOLDER_OFFSET_HIGH)
    |=> solder_offset_bits[15:8] == $past(REG_REQUEST.wdata) && $stable(solder_offset_bits[7:0]);
  endproperty
  a_off_high_write: assert property (p_off_high_write) else $error("19h not in offset bits 15:8"); // [R8]

  property p_mid_read;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.read && REG_REQUEST.addr == ADDR_REFERENCE_PRESSURE_MID)
    |=> REG_RVALID && REG_RDATA == $past(reference_pressure_bits[15:8]);
  endproperty
  a_mid_read: assert property (p_mid_read) else $error("16h reads wrong"); // [R2]

  property p_high_read;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.read && REG_REQUEST.addr == ADDR_REFERENCE_PRESSURE_HIGH)
    |=> REG_RVALID && REG_RDATA == $past(reference_pressure_bits[23:16]);
  endproperty
  a_high_read: assert property (p_high_read) else $error("17h reads wrong"); // [R3]

  property p_off_low_read;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.read && REG_REQUEST.addr == ADDR_SOLDER_OFFSET_LOW)
    |=> REG_RVALID && REG_RDATA == $past(solder_offset_bits[7:0]);
  endproperty
  a_off_low_read: assert property (p_off_low_read) else $error("18h reads wrong"); // [R5]

  property p_off_high_read;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.read && REG_REQUEST.addr == ADDR_SOLDER_OFFSET_HIGH)
    |=> REG_RVALID && REG_RDATA == $past(solder_offset_bits[15:8]);
  endproperty
  a_off_high_read: assert property (p_off_high_read) else $error("19h reads wrong"); // [R8]

  // a stray write outside the bank must not disturb any byte
  property p_unmapped_write;
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_REQUEST.write && !in_range)
    |=> $stable(reference_pressure_bits) && $stable(solder_offset_bits);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed the bank"); // [R1]

  property p_rvalid_follows;
    @(posedge CLOCK) disable iff (SYS_RST)
    1'b1
    |=> REG_RVALID == $past(REG_REQUEST.read);
  endproperty
  a_rvalid_follows: assert property (p_rvalid_follows) else $error("read valid not one cycle after strobe"); // [R1]

  property p_rdata_hold;
    @(posedge CLOCK) disable iff (SYS_RST)
    !REG_REQUEST.read
    |=> $stable(REG_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read"); // [R1]

  property p_result_valid;
    @(posedge CLOCK) disable iff (SYS_RST)
    1'b1
    |=> PRESSURE_RESULT.valid == $past(RAW_PRESSURE.valid);
  endproperty
  a_result_valid: assert property (p_result_valid) else $error("result valid not one cycle after sample"); // [R4]

  property p_result_hold;
    @(posedge CLOCK) disable iff (SYS_RST)
    !RAW_PRESSURE.valid
    |=> $stable(PRESSURE_RESULT.value);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved without a sample"); // [R7]

endmodule
`default_nettype wire

// ---- pressure_reference_offset_pkg.sv ----
package pressure_reference_offset_pkg;

  localparam int REG_ADDR_WIDTH = 8;
  localparam int REG_DATA_WIDTH = 8;
  localparam int PRESSURE_WIDTH = 24;
  localparam int OFFSET_WIDTH = 16;
  localparam int BYTE_COUNT = 5;

  localparam logic [7:0] ADDR_REFERENCE_PRESSURE_LOW = 8'h15;
  localparam logic [7:0] ADDR_REFERENCE_PRESSURE_MID = 8'h16;
  localparam logic [7:0] ADDR_REFERENCE_PRESSURE_HIGH = 8'h17;
  localparam logic [7:0] ADDR_SOLDER_OFFSET_LOW = 8'h18;
  localparam logic [7:0] ADDR_SOLDER_OFFSET_HIGH = 8'h19;

  localparam logic [7:0] BYTE_RESET_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // register byte indices inside the bank, counted from the lowest address
  localparam int IDX_REF_LOW = 0;
  localparam int IDX_REF_MID = 1;
  localparam int IDX_REF_HIGH = 2;
  localparam int IDX_OFF_LOW = 3;
  localparam int IDX_OFF_HIGH = 4;

  typedef struct packed {
    logic valid;
    logic [PRESSURE_WIDTH-1:0] value;
  } sample_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [REG_ADDR_WIDTH-1:0] addr;
    logic [REG_DATA_WIDTH-1:0] wdata;
  } reg_request_type;

endpackage

// ---- host_byte_register.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_byte_register
  import pressure_reference_offset_pkg::*;
#(
  parameter logic [7:0] ADDRESS = 8'h00
) (
  input wire logic clock,
  input wire logic reset,
  input wire reg_request_type request,
  output logic [REG_DATA_WIDTH-1:0] value
);

  wire hit;

  assign hit = request.write && (request.addr == ADDRESS);

  always_ff @(posedge clock) begin
    if (reset) begin
      value <= BYTE_RESET_VALUE;
    end else if (hit) begin
      value <= request.wdata;
    end
  end

endmodule
`default_nettype wire

// ---- tb_pressure_reference_offset_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_pressure_reference_offset_regs import pressure_reference_offset_pkg::*;;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  reg_request_type req = '0;
  sample_type raw = '0;
  logic [7:0] rdata;
  logic rvalid;
  sample_type res;
  int miscompares = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  pressure_reference_offset_regs u_pressure_reference_offset_regs (
    .CLOCK(clock), .SYS_RST(sys_rst), .REG_REQUEST(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .RAW_PRESSURE(raw), .PRESSURE_RESULT(res)
  );
  initial begin
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // write strobe is left up: the next task overwrites it, so writes run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int k;
    @(negedge clock);
    req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    req = '0;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++) begin
      @(negedge clock);
    end
    if (rvalid !== 1'b1) begin
      miscompares++;
      end_sim();
    end else begin
      chk(25'(rdata), 25'(e));
      @(negedge clock);
      chk(25'(rvalid), 25'h0);
    end
  endtask
  task automatic ps(input logic [23:0] v, input logic [23:0] e);
    @(negedge clock);
    req = '0;
    raw = '{valid: 1'b1, value: v};
    @(negedge clock);
    raw.valid = 1'b0;
    chk(res, {1'b1, e});
    @(negedge clock);
    chk(25'(res.valid), 25'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (logic [7:0] i = 8'h00; i < 8'h05; i++) begin
      rd(ADDR_REFERENCE_PRESSURE_LOW + i, BYTE_RESET_VALUE);
    end
    ps(24'h123456, 24'h123456);
  endtask
  // back-to-back writes, then an unmapped write must leave the bank untouched
  task automatic t_rw;
    for (logic [7:0] i = 8'h00; i < 8'h05; i++) begin
      wr(ADDR_REFERENCE_PRESSURE_LOW + i, 8'hA1 + 8'h11 * i);
    end
    wr(8'h1A, 8'h77);
    for (logic [7:0] i = 8'h00; i < 8'h05; i++) begin
      rd(ADDR_REFERENCE_PRESSURE_LOW + i, 8'hA1 + 8'h11 * i);
    end
    rd(8'h1A, UNMAPPED_READ_VALUE);
    rd(8'h14, UNMAPPED_READ_VALUE);
  endtask
  // read right after a write, then a write and a read in one cycle that must return the old byte
  task automatic t_walk;
    wr(ADDR_REFERENCE_PRESSURE_LOW, 8'h5A);
    rd(ADDR_REFERENCE_PRESSURE_LOW, 8'h5A);
    @(negedge clock);
    req = '{write: 1'b1, read: 1'b1, addr: ADDR_SOLDER_OFFSET_HIGH, wdata: 8'h3C};
    @(negedge clock);
    req = '0;
    chk(25'(rvalid), 25'h1);
    chk(25'(rdata), 25'(8'hE5));
    rd(ADDR_SOLDER_OFFSET_HIGH, 8'h3C);
  endtask
  // reset in mid-run must clear bytes 19h and 17h, read back directly, and the result path
  task automatic t_reset_again;
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    rd(ADDR_SOLDER_OFFSET_HIGH, BYTE_RESET_VALUE);
    rd(ADDR_REFERENCE_PRESSURE_HIGH, BYTE_RESET_VALUE);
    ps(24'h000042, 24'h000042);
  endtask
  // negative offset, then a positive one with the reference wrapping at 24 bits
  task automatic t_sum;
    wr(ADDR_REFERENCE_PRESSURE_LOW, 8'h10);
    wr(ADDR_REFERENCE_PRESSURE_MID, 8'h00);
    wr(ADDR_REFERENCE_PRESSURE_HIGH, 8'h00);
    wr(ADDR_SOLDER_OFFSET_LOW, 8'hFF);
    wr(ADDR_SOLDER_OFFSET_HIGH, 8'hFF);
    ps(24'h000100, 24'h00010F);
    wr(ADDR_REFERENCE_PRESSURE_LOW, 8'hFF);
    wr(ADDR_REFERENCE_PRESSURE_MID, 8'hFF);
    wr(ADDR_REFERENCE_PRESSURE_HIGH, 8'hFF);
    wr(ADDR_SOLDER_OFFSET_LOW, 8'h02);
    wr(ADDR_SOLDER_OFFSET_HIGH, 8'h01);
    ps(24'h000005, 24'h000106);
  endtask
  initial begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    t_reset();
    t_rw();
    t_walk();
    t_sum();
    t_reset_again();
    end_sim();
  end
endmodule
`default_nettype wire
